// ---- orient_wake_defs.vh ----
// constants for the orientation and wake-up event logic
// assumes acceleration samples in signed units of 1/1024 g on every full scale
`ifndef ORIENT_WAKE_DEFS_VH
`define ORIENT_WAKE_DEFS_VH

// register offsets on the register port
`define OFS_ACCEL_CTRL 7'h20
`define OFS_CONTROL_NINE 7'h21
`define OFS_TAP_CFG_ZERO 7'h22
`define OFS_TAP_ORIENT_THS 7'h23
`define OFS_WAKE_THS 7'h24
`define OFS_WAKE_DUR 7'h25
`define OFS_INACT_DUR 7'h26
`define OFS_FUNC_ENABLE 7'h27
`define OFS_PIN_ONE 7'h28
`define OFS_PIN_TWO 7'h29
`define OFS_WAKE_SRC 7'h2a
`define OFS_ORIENT_SRC 7'h2b
`define OFS_COMBINED_SRC 7'h2c

// reset value of every writable register
`define REG_RESET 8'h00

// field positions
`define ODR_HI 3
`define ODR_LO 0
`define FAST_SETTL_BIT 5
`define LATCH_BIT 0
`define HPF_SEL_BIT 4
`define SETTL_MASK_BIT 5
`define LP6D_BIT 6
`define SIXD_HI 6
`define SIXD_LO 5
`define WAKEUP_THRESHOLD_COUNT_HI 5
`define WAKEUP_THRESHOLD_COUNT_LO 0
`define RES_HI 6
`define RES_LO 4
`define WDUR_HI 6
`define WDUR_LO 5
`define GLOBAL_EN_BIT 7
`define ROUTE_ORIENT_BIT 2
`define ROUTE_WAKE_BIT 5

// source register layouts
`define WSRC_WAKE_BIT 3
`define ALL_WAKE_BIT 3
`define ALL_ORIENT_BIT 4

// orientation thresholds, 1024 * sin(angle)
`define ORIENT_THR_80 16'h03f0
`define ORIENT_THR_70 16'h03c2
`define ORIENT_THR_60 16'h0377
`define ORIENT_THR_50 16'h0310

// samples masked after enable while filters settle
`define SETTLE_SAMPLES 2'h2

`endif

// ---- orient_wake_logic.v ----
// orientation (6d) and wake-up event logic with pin routing and latching
// assumes filtered sample buses and the sample strobe come from logic on sys_clk_in
`timescale 1ns/1ps
`default_nettype none
`include "orient_wake_defs.vh"

// What this block does
// [R1] zero duration: wake event on every sample whose magnitude exceeds threshold
// [R2] wake threshold is count times resolution step; code 011 means 62.5 mg
// [R3] slope mode uses half current-minus-previous; previous is zero after enable
// [R4] a spurious first-sample wake event lasts one sample period, then releases
// [R5] fast settling plus settling mask suppress all events while filters settle
// [R6] host programs everything first, accel control register last to start sampling
// [R7] six orientations; event only on a change, never while orientation holds
// [R8] orientation event needs one axis above, two below, for two samples
// [R9] orientation source bit 6 is the change flag, bit 7 reads zero
// [R10] bits 5,3,1 flag z,y,x positive and above threshold
// [R11] bits 4,2,0 flag z,y,x negative and above threshold
// [R12] threshold field codes 00..11 select 80,70,60,50 degrees, any full scale
// [R13] lowpass select bit feeds orientation from the second lowpass output
// [R14] orientation needs global enable; each pin needs its route bit; readable
// [R15] unlatched orientation request lasts exactly one sample period
// [R16] latched routed request holds until source read; read clears and re-arms
// [R17] position flags ignore latching and hold the last orientation detected while events are allowed
// [R18] latching without any pin route behaves as unlatched
// [R19] writing 40h to threshold register selects code 10, 60 degrees
// [R20] wake compares absolute filtered value against unsigned threshold
// [R21] unlatched wake event clears when data falls back under threshold
// [R22] conditions evaluated and flags updated once per sample strobe
// [R23] combined source read clears latched orientation like orientation read
module orient_wake_logic (
    // clock and reset
    input wire sys_clk_in,
    input wire reset_in,
    // register port
    input wire [6:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    output reg reg_rvalid_out,
    // sample stream
    input wire sample_strobe_in,
    input wire [15:0] accel_x_in,
    input wire [15:0] accel_y_in,
    input wire [15:0] accel_z_in,
    input wire [15:0] second_lowpass_x_in,
    input wire [15:0] second_lowpass_y_in,
    input wire [15:0] second_lowpass_z_in,
    input wire [15:0] hpf_x_in,
    input wire [15:0] hpf_y_in,
    input wire [15:0] hpf_z_in,
    // interrupt pins
    output reg first_irq_pin_out,
    output reg second_irq_pin_out
);

    function [15:0] magnitude;
        input [15:0] v;
        begin
            magnitude = v[15] ? (~v + 16'h0001) : v;
        end
    endfunction

    function [15:0] wake_threshold;
        input [5:0] count;
        input [2:0] res;
        reg [15:0] base;
        begin
            base = {10'h000, count};
            case (res)
                3'h0: wake_threshold = base << 3;
                3'h1: wake_threshold = base << 4;
                3'h2: wake_threshold = base << 5;
                3'h3: wake_threshold = base << 6;
                3'h4: wake_threshold = base << 7;
                default: wake_threshold = base << 8;
            endcase
        end
    endfunction

    function [15:0] orient_threshold;
        input [1:0] code;
        begin
            case (code)
                2'h0: orient_threshold = `ORIENT_THR_80;
                2'h1: orient_threshold = `ORIENT_THR_70;
                2'h2: orient_threshold = `ORIENT_THR_60;
                default: orient_threshold = `ORIENT_THR_50;
            endcase
        end
    endfunction

    reg [7:0] accel_control_register;
    reg [7:0] control_nine;
    reg [7:0] tap_config_zero;
    reg [7:0] tap_orient_threshold;
    reg [7:0] wakeup_threshold_register;
    reg [7:0] wakeup_duration_register;
    reg [7:0] inactivity_duration_register;
    reg [7:0] functions_enable;
    reg [7:0] pin_one_routing;
    reg [7:0] pin_two_routing;

    reg [1:0] settle_cnt;
    reg [2:0] wake_run;
    reg wake_flag;
    reg [2:0] wake_axes;
    reg [5:0] prev_cand;
    reg [5:0] position;
    reg orientation_change_flag;
    reg [7:0] rd_value;

    wire [47:0] raw_bus = {accel_z_in, accel_y_in, accel_x_in};
    wire [47:0] lp2_bus = {second_lowpass_z_in, second_lowpass_y_in, second_lowpass_x_in};
    wire [47:0] hpf_bus = {hpf_z_in, hpf_y_in, hpf_x_in};

    wire sampling = |accel_control_register[`ODR_HI:`ODR_LO];
    wire take = sample_strobe_in && sampling; // [R22]
    wire global_en = functions_enable[`GLOBAL_EN_BIT];
    wire latch_mode_bit = tap_config_zero[`LATCH_BIT];
    wire hpf_select = tap_config_zero[`HPF_SEL_BIT];
    wire settling_mask_bit = tap_config_zero[`SETTL_MASK_BIT];
    wire orientation_lowpass_select = tap_config_zero[`LP6D_BIT];
    wire fast_settling_mode = control_nine[`FAST_SETTL_BIT];
    wire orient_route_pin_one = pin_one_routing[`ROUTE_ORIENT_BIT];
    wire orient_route_pin_two = pin_two_routing[`ROUTE_ORIENT_BIT];
    wire wake_route_pin_one = pin_one_routing[`ROUTE_WAKE_BIT];
    wire wake_route_pin_two = pin_two_routing[`ROUTE_WAKE_BIT];

    // the settling mask only exists with both bits set
    wire settling = (settle_cnt != `SETTLE_SAMPLES);
    wire masked = fast_settling_mode && settling_mask_bit && settling; // [R5]
    wire allow = global_en && !masked; // [R14]

    wire [15:0] wake_thr = wake_threshold(wakeup_threshold_register[`WAKEUP_THRESHOLD_COUNT_HI:`WAKEUP_THRESHOLD_COUNT_LO],
        inactivity_duration_register[`RES_HI:`RES_LO]); // [R2]
    wire [1:0] wake_dur = wakeup_duration_register[`WDUR_HI:`WDUR_LO];
    wire [15:0] orient_thr = orient_threshold(tap_orient_threshold[`SIXD_HI:`SIXD_LO]); // [R12] [R19]

    // unrouted latching would leave nobody to clear it
    wire orient_latch = latch_mode_bit && (orient_route_pin_one || orient_route_pin_two); // [R18]
    wire wake_latch = latch_mode_bit && (wake_route_pin_one || wake_route_pin_two); // [R18]

    wire rd_orient = reg_rd_in && (reg_addr_in == `OFS_ORIENT_SRC);
    wire rd_wake = reg_rd_in && (reg_addr_in == `OFS_WAKE_SRC);
    wire rd_all = reg_rd_in && (reg_addr_in == `OFS_COMBINED_SRC);
    wire orient_clr = (rd_orient || rd_all) && orient_latch; // [R16] [R23]
    wire wake_clr = (rd_wake || rd_all) && wake_latch;

    wire [2:0] wake_over;
    wire [2:0] orient_hi;
    wire [2:0] orient_lo;

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1)
        begin : axis
            reg [15:0] prev_sample;
            wire [15:0] cur = raw_bus[i*16 +: 16];
            wire [16:0] diff = {cur[15], cur} - {prev_sample[15], prev_sample};
            wire [15:0] slope = diff[16:1]; // [R3]
            wire [15:0] wsel = hpf_select ? hpf_bus[i*16 +: 16] : slope;
            wire [15:0] osel = orientation_lowpass_select ? lp2_bus[i*16 +: 16] : cur; // [R13]
            wire osel_above = magnitude(osel) > orient_thr;
            assign wake_over[i] = magnitude(wsel) > wake_thr; // [R20]
            assign orient_hi[i] = !osel[15] && osel_above; // [R10]
            assign orient_lo[i] = osel[15] && osel_above; // [R11]

            // previous sample reads as zero on the first sample after enable
            always @(posedge sys_clk_in or posedge reset_in)
            begin
                if (reset_in)
                    prev_sample <= 16'h0000;
                else if (!sampling)
                    prev_sample <= 16'h0000; // [R3]
                else if (sample_strobe_in)
                    prev_sample <= cur;
            end
        end
    endgenerate

    wire any_over = |wake_over;
    wire [2:0] next_wake_run = !any_over ? 3'h0 :
        ((wake_run == 3'h7) ? wake_run : wake_run + 3'h1);
    // dur 0 fires on the first exceeding sample
    wire wake_cond = any_over && (next_wake_run > {1'b0, wake_dur}); // [R1]

    wire [2:0] above = orient_hi | orient_lo;
    wire one_axis = (above == 3'h1) || (above == 3'h2) || (above == 3'h4);
    wire [5:0] cand = one_axis ?
        {orient_hi[2], orient_lo[2], orient_hi[1], orient_lo[1], orient_hi[0], orient_lo[0]} :
        6'h00; // [R8]
    wire stable = (cand != 6'h00) && (cand == prev_cand); // [R8]
    wire orient_event = stable && (cand != position); // [R7]

    // configuration registers
    always @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            accel_control_register <= `REG_RESET;
            control_nine <= `REG_RESET;
            tap_config_zero <= `REG_RESET;
            tap_orient_threshold <= `REG_RESET;
            wakeup_threshold_register <= `REG_RESET;
            wakeup_duration_register <= `REG_RESET;
            inactivity_duration_register <= `REG_RESET;
            functions_enable <= `REG_RESET;
            pin_one_routing <= `REG_RESET;
            pin_two_routing <= `REG_RESET;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                `OFS_ACCEL_CTRL: accel_control_register <= reg_wdata_in; // [R6]
                `OFS_CONTROL_NINE: control_nine <= reg_wdata_in;
                `OFS_TAP_CFG_ZERO: tap_config_zero <= reg_wdata_in;
                `OFS_TAP_ORIENT_THS: tap_orient_threshold <= reg_wdata_in;
                `OFS_WAKE_THS: wakeup_threshold_register <= reg_wdata_in;
                `OFS_WAKE_DUR: wakeup_duration_register <= reg_wdata_in;
                `OFS_INACT_DUR: inactivity_duration_register <= reg_wdata_in;
                `OFS_FUNC_ENABLE: functions_enable <= reg_wdata_in;
                `OFS_PIN_ONE: pin_one_routing <= reg_wdata_in;
                `OFS_PIN_TWO: pin_two_routing <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // settling counter and wake run length
    always @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            settle_cnt <= 2'h0;
            wake_run <= 3'h0;
        end
        else if (!sampling)
        begin
            settle_cnt <= 2'h0;
            wake_run <= 3'h0;
        end
        else if (sample_strobe_in)
        begin
            if (settling)
                settle_cnt <= settle_cnt + 2'h1;
            wake_run <= next_wake_run;
        end
    end

    // wake flag; a new event beats a clearing read in the same cycle
    always @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wake_flag <= 1'b0;
            wake_axes <= 3'h0;
        end
        else if (take && allow && wake_cond)
        begin
            wake_flag <= 1'b1; // [R1]
            wake_axes <= wake_over;
        end
        else if (take && !wake_latch)
        begin
            wake_flag <= 1'b0; // [R21] [R4]
            wake_axes <= 3'h0;
        end
        else if (wake_clr)
        begin
            wake_flag <= 1'b0;
            wake_axes <= 3'h0;
        end
    end

    // orientation tracking
    always @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            prev_cand <= 6'h00;
            position <= 6'h00;
        end
        else if (!sampling)
            prev_cand <= 6'h00;
        else if (sample_strobe_in)
        begin
            prev_cand <= cand;
            if (allow && orient_event)
                position <= cand; // [R17]
        end
    end

    // orientation change flag; set wins over a clearing read
    always @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
            orientation_change_flag <= 1'b0;
        else if (take && allow && orient_event)
            orientation_change_flag <= 1'b1; // [R7] [R9]
        else if (take && !orient_latch)
            orientation_change_flag <= 1'b0; // [R15]
        else if (orient_clr)
            orientation_change_flag <= 1'b0; // [R16]
    end

    always @*
    begin
        rd_value = 8'h00;
        case (reg_addr_in)
            `OFS_ACCEL_CTRL: rd_value = accel_control_register;
            `OFS_CONTROL_NINE: rd_value = control_nine;
            `OFS_TAP_CFG_ZERO: rd_value = tap_config_zero;
            `OFS_TAP_ORIENT_THS: rd_value = tap_orient_threshold;
            `OFS_WAKE_THS: rd_value = wakeup_threshold_register;
            `OFS_WAKE_DUR: rd_value = wakeup_duration_register;
            `OFS_INACT_DUR: rd_value = inactivity_duration_register;
            `OFS_FUNC_ENABLE: rd_value = functions_enable;
            `OFS_PIN_ONE: rd_value = pin_one_routing;
            `OFS_PIN_TWO: rd_value = pin_two_routing;
            `OFS_WAKE_SRC: rd_value = {4'h0, wake_flag, wake_axes};
            `OFS_ORIENT_SRC: rd_value = {1'b0, orientation_change_flag, position}; // [R9] [R17]
            `OFS_COMBINED_SRC:
            begin
                rd_value[`ALL_ORIENT_BIT] = orientation_change_flag; // [R14]
                rd_value[`ALL_WAKE_BIT] = wake_flag;
            end
            default: rd_value = 8'h00;
        endcase
    end

    // read data and pins
    always @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
            first_irq_pin_out <= 1'b0;
            second_irq_pin_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in)
                reg_rdata_out <= rd_value;
            first_irq_pin_out <= global_en &&
                ((orientation_change_flag && orient_route_pin_one) ||
                (wake_flag && wake_route_pin_one)); // [R14]
            second_irq_pin_out <= global_en &&
                ((orientation_change_flag && orient_route_pin_two) ||
                (wake_flag && wake_route_pin_two)); // [R14]
        end
    end

endmodule // orient_wake_logic
`default_nettype wire

// ---- orient_wake_properties.sv ----
// concurrent checks on the ports of orient_wake_logic
// assumes one clock domain and the register offsets of the defs header
`timescale 1ns/1ps
`default_nettype none
`include "orient_wake_defs.vh"
module orient_wake_properties (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // register port
    input wire logic [6:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    // samples and pins
    input wire logic sample_strobe_in,
    input wire logic first_irq_pin_out,
    input wire logic second_irq_pin_out
);
default clocking @(posedge sys_clk_in);
endclocking
default disable iff (reset_in);
// shadow of the latch bit, since the checker cannot see registers
logic latch_q;
always_ff @(posedge sys_clk_in or posedge reset_in)
begin
    if (reset_in)
        latch_q <= 1'b0;
    else if (reg_wr_in && reg_addr_in == `OFS_TAP_CFG_ZERO)
        latch_q <= reg_wdata_in[`LATCH_BIT];
end
a_read_answered: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read strobe without answer");
a_answer_has_read: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("read answer without read");
a_orient_top_zero: assert property (reg_rvalid_out &&
    $past(reg_addr_in) == `OFS_ORIENT_SRC |-> reg_rdata_out[7] == 1'b0)
    else $error("orientation source bit 7 set");
a_position_one_hot: assert property (reg_rvalid_out &&
    $past(reg_addr_in) == `OFS_ORIENT_SRC |-> $onehot0(reg_rdata_out[5:0]))
    else $error("more than one face flagged");
a_unmapped_zero: assert property (reg_rvalid_out &&
    ($past(reg_addr_in) < `OFS_ACCEL_CTRL || $past(reg_addr_in) > `OFS_COMBINED_SRC)
    |-> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
a_pin_one_cause: assert property ($changed(first_irq_pin_out) |->
    $past(sample_strobe_in, 2) || $past(reg_wr_in, 2) || $past(reg_rd_in, 2))
    else $error("pin one moved alone");
a_pin_two_cause: assert property ($changed(second_irq_pin_out) |->
    $past(sample_strobe_in, 2) || $past(reg_wr_in, 2) || $past(reg_rd_in, 2))
    else $error("pin two moved alone");
// latch must have stood before the flag dropped, not just been written
a_latched_pin_holds: assert property ($fell(first_irq_pin_out) && latch_q &&
    $past(latch_q, 2) |-> $past(reg_rd_in, 2) || $past(reg_wr_in, 2))
    else $error("latched pin fell without read");
endmodule // orient_wake_properties
bind orient_wake_logic orient_wake_properties u_orient_wake_properties (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .sample_strobe_in(sample_strobe_in), .first_irq_pin_out(first_irq_pin_out),
    .second_irq_pin_out(second_irq_pin_out));
`default_nettype wire

// ---- orient_host.sv ----
// host processor model driving the register port
// assumes one-cycle read and write strobes on the system clock
`timescale 1ns/1ps
`default_nettype none
module orient_host (
    // clock
    input wire logic clk_in,
    // register port
    output var logic [6:0] reg_addr_out,
    output var logic [7:0] reg_wdata_out,
    output var logic reg_wr_out,
    output var logic reg_rd_out
);
initial
begin
    reg_addr_out = 7'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
end
task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    // released bus must not keep showing the old value
    reg_wdata_out <= ~d;
endtask
task automatic rd_reg(input logic [6:0] a);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clk_in);
    reg_rd_out <= 1'b0;
endtask
endmodule // orient_host
`default_nettype wire

// ---- tb_orient_wake_logic.sv ----
// self-checking bench for orient_wake_logic
// assumes orient_host drives the register port
`timescale 1ns/1ps
`default_nettype none
`include "orient_wake_defs.vh"
module tb_orient_wake_logic;
logic sys_clk;
logic reset;
logic strobe;
logic wr_strobe;
logic rd_strobe;
logic rvalid;
logic pin_one;
logic pin_two;
logic [6:0] addr;
logic [7:0] wdata;
logic [7:0] rdata;
logic [15:0] lp_x;
logic [15:0] lp_y;
logic [15:0] lp_z;
logic [15:0] hp_x;
logic [15:0] thr [4];
logic [7:0] exp_q [$];
int errors;
int num_checks;
int pin_cnt;
orient_host u_orient_host (.clk_in(sys_clk), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr_strobe), .reg_rd_out(rd_strobe));
// raw path rotated so reading the wrong source shows another face
orient_wake_logic u_orient_wake_logic (.sys_clk_in(sys_clk), .reset_in(reset),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_strobe), .reg_rd_in(rd_strobe),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .sample_strobe_in(strobe),
    .accel_x_in(lp_y), .accel_y_in(lp_z), .accel_z_in(lp_x),
    .second_lowpass_x_in(lp_x), .second_lowpass_y_in(lp_y), .second_lowpass_z_in(lp_z),
    .hpf_x_in(hp_x), .hpf_y_in(16'h0000), .hpf_z_in(16'h0000),
    .first_irq_pin_out(pin_one), .second_irq_pin_out(pin_two));
initial
begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
end
task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
        errors++;
        $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
endtask
task automatic chk_pin(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
        errors++;
        $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
endtask
task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_orient_host.rd_reg(a);
endtask
task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_orient_host.wr_reg(a, d);
endtask
// one sample every ten clocks
task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(posedge sys_clk);
    lp_x <= x;
    lp_y <= y;
    lp_z <= z;
    strobe <= 1'b1;
    @(posedge sys_clk);
    strobe <= 1'b0;
    repeat (8) @(posedge sys_clk);
endtask
always @(negedge sys_clk)
begin
    if (rvalid === 1'b1)
    begin
        if (exp_q.size() == 0)
        begin
            errors++;
            $display("[FAIL] read data expected none seen %h", rdata);
        end
        else
            chk8("read data", exp_q.pop_front(), rdata);
    end
end
always @(posedge sys_clk)
begin
    if (pin_one === 1'b1)
        pin_cnt <= pin_cnt + 1;
end
initial
begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("[FAIL] run length expected finished seen timeout");
    wrap_up();
end
initial
begin
    reset = 1'b1;
    strobe = 1'b0;
    lp_x = 16'h0000;
    lp_y = 16'h0000;
    lp_z = 16'h0000;
    hp_x = 16'h0000;
    errors = 0;
    num_checks = 0;
    pin_cnt = 0;
    thr = '{`ORIENT_THR_80, `ORIENT_THR_70, `ORIENT_THR_60, `ORIENT_THR_50};
    void'($urandom(32'h5876));
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    for (int a = 32; a <= 44; a++) rd(7'(a), 8'h00);
    wr(`OFS_ORIENT_SRC, 8'hff);
    wr(7'h40, 8'h5a);
    rd(`OFS_ORIENT_SRC, 8'h00);
    rd(7'h40, 8'h00);
    $display("test reset done");
    wr(`OFS_TAP_CFG_ZERO, 8'h41);
    wr(`OFS_TAP_ORIENT_THS, 8'h40);
    wr(`OFS_PIN_ONE, 8'h04);
    wr(`OFS_FUNC_ENABLE, 8'h80);
    wr(`OFS_ACCEL_CTRL, 8'h08);
    smp(16'h0000, 16'h0000, 16'h0400);
    smp(16'h0000, 16'h0000, 16'h0400);
    chk_pin("pin one", 1'b1, pin_one);
    rd(`OFS_ORIENT_SRC, 8'h60);
    repeat (3) @(posedge sys_clk);
    chk_pin("pin one", 1'b0, pin_one);
    rd(`OFS_ORIENT_SRC, 8'h20);
    smp(16'h0400, 16'h0000, 16'h0000);
    smp(16'h0400, 16'h0000, 16'h0000);
    chk_pin("pin one", 1'b1, pin_one);
    rd(`OFS_COMBINED_SRC, 8'h10);
    repeat (3) @(posedge sys_clk);
    chk_pin("pin one", 1'b0, pin_one);
    rd(`OFS_ORIENT_SRC, 8'h02);
    $display("test latched done");
    wr(`OFS_TAP_CFG_ZERO, 8'h40);
    @(negedge sys_clk);
    pin_cnt = 0;
    repeat (3) smp(16'h0000, 16'hfc00, 16'h0000);
    chk8("pulse length", 8'd10, 8'(pin_cnt));
    rd(`OFS_ORIENT_SRC, 8'h04);
    for (int c = 0; c < 4; c++)
    begin
        wr(`OFS_TAP_ORIENT_THS, {1'b0, 2'(c), 5'h00});
        repeat (2) smp(16'h0400, 16'h0000, 16'h0000);
        // exactly at threshold is not above it
        repeat (2) smp(16'h0000, 16'h0000, thr[c]);
        rd(`OFS_ORIENT_SRC, 8'h02);
        repeat (2) smp(16'h0000, 16'h0000, thr[c] + 16'h0001);
        rd(`OFS_ORIENT_SRC, 8'h60);
    end
    smp(16'h0000, 16'h0000, thr[3] + 16'h0001);
    rd(`OFS_ORIENT_SRC, 8'h20);
    wr(`OFS_TAP_CFG_ZERO, 8'h41);
    wr(`OFS_FUNC_ENABLE, 8'h00);
    repeat (2) smp(16'h0400, 16'h0000, 16'h0000);
    chk_pin("pin one", 1'b0, pin_one);
    rd(`OFS_ORIENT_SRC, 8'h20);
    $display("test orientation done");
    wr(`OFS_TAP_CFG_ZERO, 8'h10);
    wr(`OFS_INACT_DUR, 8'h30);
    wr(`OFS_WAKE_THS, 8'h01);
    wr(`OFS_WAKE_DUR, 8'h00);
    wr(`OFS_PIN_TWO, 8'h20);
    wr(`OFS_FUNC_ENABLE, 8'h80);
    hp_x <= 16'h0000 - (16'd65 + 16'($urandom % 900));
    smp(16'h0400, 16'h0000, 16'h0000);
    chk_pin("pin two", 1'b1, pin_two);
    rd(`OFS_WAKE_SRC, 8'h09);
    rd(`OFS_COMBINED_SRC, 8'h08);
    hp_x <= 16'd64;
    smp(16'h0400, 16'h0000, 16'h0000);
    chk_pin("pin two", 1'b0, pin_two);
    rd(`OFS_WAKE_SRC, 8'h00);
    // slope path: restart so the first slope sees a zero history
    wr(`OFS_ACCEL_CTRL, 8'h00);
    wr(`OFS_TAP_CFG_ZERO, 8'h00);
    wr(`OFS_ACCEL_CTRL, 8'h08);
    smp(16'h0400, 16'h0000, 16'h0000);
    chk_pin("pin two", 1'b1, pin_two);
    rd(`OFS_WAKE_SRC, 8'h0c);
    smp(16'h0400, 16'h0000, 16'h0000);
    chk_pin("pin two", 1'b0, pin_two);
    // latch bit set but wake routed nowhere
    wr(`OFS_TAP_CFG_ZERO, 8'h01);
    wr(`OFS_PIN_TWO, 8'h00);
    smp(16'h0000, 16'h0000, 16'h0000);
    rd(`OFS_WAKE_SRC, 8'h0c);
    smp(16'h0000, 16'h0000, 16'h0000);
    rd(`OFS_WAKE_SRC, 8'h00);
    // settling mask hides the first two samples after enable
    wr(`OFS_ACCEL_CTRL, 8'h00);
    wr(`OFS_CONTROL_NINE, 8'h20);
    wr(`OFS_TAP_CFG_ZERO, 8'h30);
    wr(`OFS_PIN_TWO, 8'h20);
    wr(`OFS_ACCEL_CTRL, 8'h08);
    hp_x <= 16'h0100;
    repeat (2) smp(16'h0000, 16'h0000, 16'h0000);
    chk_pin("pin two", 1'b0, pin_two);
    smp(16'h0000, 16'h0000, 16'h0000);
    chk_pin("pin two", 1'b1, pin_two);
    $display("test wake done");
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge sys_clk);
    if (exp_q.size() > 0)
    begin
        errors++;
        $display("[FAIL] pending reads expected 0 seen %0d", exp_q.size());
    end
    wrap_up();
end
endmodule // tb_orient_wake_logic
`default_nettype wire
